/* core/bit_band_alias_mapper.sv */
`timescale 1ns/1ps
module bit_band_alias_mapper
    import bit_band_pkg::*;
#(
    parameter int DEPTH_WORDS = 256
) (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_write_i,
    input  wire logic [31:0] req_addr_i,
    input  wire logic [31:0] req_wdata_i,
    input  wire logic [3:0]  req_be_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [31:0]      rsp_rdata_o,
    output logic             rsp_err_o
);

    localparam int          IDXW      = (DEPTH_WORDS > 1) ? $clog2(DEPTH_WORDS) : 1;
    localparam logic [31:0] MAP_BYTES = 32'(DEPTH_WORDS * WORD_BYTES);

    typedef enum logic [1:0] {ST_IDLE, ST_DIRECT_RD, ST_ALIAS_RD} state_e;

    typedef struct packed {
        state_e          st;
        logic            ready;
        logic            rsp_valid;
        logic [31:0]     rdata;
        logic            err;
        logic            wr;
        logic [IDXW-1:0] idx;
        logic [4:0]      bitpos;
        logic            wbit;
    } state_s;

    localparam state_s STATE_RST = '{st: ST_IDLE, ready: READY_RST, rsp_valid: 1'b0,
                                     rdata: RDATA_RST, err: 1'b0, wr: 1'b0,
                                     idx: '0, bitpos: 5'h0, wbit: 1'b0};

    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------
    function automatic logic [31:0] alias_byte_off(input logic [31:0] a);
        return (a - ALIAS_BASE) >> BYTE_SHIFT;
    endfunction : alias_byte_off

    // byte lane picks the bit group, little-endian within the word
    function automatic logic [4:0] alias_bitpos(input logic [31:0] a);
        logic [31:0] off;
        off = a - ALIAS_BASE;
        return {off[BYTE_SHIFT+1:BYTE_SHIFT], off[BYTE_SHIFT-1:BIT_SHIFT]};
    endfunction : alias_bitpos

    function automatic logic [IDXW-1:0] word_idx(input logic [31:0] byte_off);
        return IDXW'(byte_off >> WORD_SHIFT);
    endfunction : word_idx

    state_s          r;
    state_s          n;
    logic            accept;
    logic            is_alias;
    logic            is_band;
    logic [31:0]     alias_off_b;
    logic [31:0]     band_off_b;
    logic            ram_en;
    logic            ram_we;
    logic [3:0]      ram_be;
    logic [IDXW-1:0] ram_addr;
    logic [31:0]     ram_wdata;
    logic [31:0]     ram_q;

    assign accept      = r.ready && req_valid_i;
    assign is_alias    = req_addr_i[31:ALIAS_SPAN_SHIFT] == ALIAS_BASE[31:ALIAS_SPAN_SHIFT];
    assign is_band     = req_addr_i[31:BAND_SPAN_SHIFT] == BAND_BASE[31:BAND_SPAN_SHIFT];
    assign alias_off_b = alias_byte_off(req_addr_i);
    assign band_off_b  = req_addr_i - BAND_BASE;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n         = r;
        n.rsp_valid = 1'b0;
        ram_en    = 1'b0;
        ram_we    = 1'b0;
        ram_be    = 4'h0;
        ram_addr  = r.idx;
        ram_wdata = 32'h0000_0000;
        case (r.st)
            ST_IDLE: begin
                if (accept) begin
                    n.err   = 1'b0;
                    n.rdata = RDATA_RST;
                    if (is_alias && alias_off_b < MAP_BYTES) begin
                        // ready drops so nothing can slip between read and write
                        ram_en   = 1'b1;
                        ram_addr = word_idx(alias_off_b);
                        n.idx    = word_idx(alias_off_b);
                        n.bitpos = alias_bitpos(req_addr_i);
                        n.wr     = req_write_i;
                        n.wbit   = req_wdata_i[0];
                        n.ready  = 1'b0;
                        n.st     = ST_ALIAS_RD;
                    end else if (is_band && band_off_b < MAP_BYTES) begin
                        ram_en   = 1'b1;
                        ram_addr = word_idx(band_off_b);
                        if (req_write_i) begin
                            // lane 0 carries the least significant byte
                            ram_we      = 1'b1;
                            ram_be      = req_be_i;
                            ram_wdata   = req_wdata_i;
                            n.rsp_valid = 1'b1;
                        end else begin
                            n.ready = 1'b0;
                            n.st    = ST_DIRECT_RD;
                        end
                    end else begin
                        // unmapped or beyond the fitted memory
                        n.err       = 1'b1;
                        n.rsp_valid = 1'b1;
                    end
                end
            end
            ST_DIRECT_RD: begin
                n.rdata     = ram_q;
                n.rsp_valid = 1'b1;
                n.ready     = 1'b1;
                n.st        = ST_IDLE;
            end
            ST_ALIAS_RD: begin
                if (r.wr) begin
                    ram_en            = 1'b1;
                    ram_we            = 1'b1;
                    ram_be            = 4'h1 << r.bitpos[4:3];
                    ram_wdata         = ram_q;
                    ram_wdata[r.bitpos] = r.wbit;
                    n.rdata           = RDATA_RST;
                end else begin
                    n.rdata = {31'h0, ram_q[r.bitpos]};
                end
                n.rsp_valid = 1'b1;
                n.ready     = 1'b1;
                n.st        = ST_IDLE;
            end
            default: begin
                n = STATE_RST;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // band memory
    // ------------------------------------------------------------
    band_ram #(
        .WORDS (DEPTH_WORDS),
        .AW    (IDXW)
    ) u_ram (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .en_i    (ram_en),
        .we_i    (ram_we),
        .be_i    (ram_be),
        .addr_i  (ram_addr),
        .wdata_i (ram_wdata),
        .q_o     (ram_q)
    );

    assign req_ready_o = r.ready;
    assign rsp_valid_o = r.rsp_valid;
    assign rsp_rdata_o = r.rdata;
    assign rsp_err_o   = r.err;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    logic acc_alias;
    assign acc_alias = accept && is_alias && alias_off_b < MAP_BYTES;

    sequence alias_wr_s;
        acc_alias && req_write_i;
    endsequence

    sequence alias_rd_s;
        acc_alias && !req_write_i ##1 r.st == ST_ALIAS_RD;
    endsequence

    alias_base_a: assert property (
        (accept && req_addr_i == ALIAS_BASE) |=> (r.idx == '0 && r.bitpos == 5'h0))
        else $error("alias base not mapped to bit 0 of byte 0");

    alias_offset_a: assert property (
        (accept && req_addr_i == ALIAS_BASE + 32'h0000_001c) |=> (r.idx == '0 && r.bitpos == 5'h7))
        else $error("alias offset 0x1c not mapped to bit 7");

    lane_order_a: assert property (
        acc_alias |=> r.bitpos == {$past(req_addr_i[6:5]), $past(req_addr_i[4:2])})
        else $error("alias byte lane not little-endian");

    single_bit_a: assert property (
        (r.st == ST_ALIAS_RD && r.wr) |-> (ram_we && $onehot(ram_be)
            && ((ram_wdata ^ ram_q) & ~(32'h1 << r.bitpos)) == 32'h0))
        else $error("alias write touched more than one bit");

    bit_value_a: assert property (
        alias_wr_s |=> ram_wdata[r.bitpos] == $past(req_wdata_i[0]))
        else $error("alias write bit value wrong");

    high_bits_a: assert property (
        alias_wr_s |=> $countones((ram_wdata ^ ram_q) & ~(32'h1 << r.bitpos)) == 0)
        else $error("alias write upper data bits leaked");

    read_value_a: assert property (
        alias_rd_s |=> (rsp_valid_o && !rsp_err_o
            && rsp_rdata_o == (($past(ram_q) >> $past(r.bitpos)) & 32'h1)))
        else $error("alias read value wrong");

    direct_word_a: assert property (
        (accept && is_band && !is_alias && band_off_b < MAP_BYTES && req_write_i)
            |-> (ram_we && ram_addr == IDXW'(band_off_b >> 2)) ##1 rsp_valid_o)
        else $error("direct write word index wrong");

    rmw_atomic_a: assert property (
        alias_wr_s |=> (!req_ready_o && ram_we) ##1 (rsp_valid_o && req_ready_o))
        else $error("alias read-modify-write not indivisible");

endmodule : bit_band_alias_mapper

/* core/bit_band_pkg.sv */
package bit_band_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [31:0] ALIAS_BASE      = 32'h2200_0000;
    localparam logic [31:0] BAND_BASE       = 32'h2000_0000;
    localparam int          ALIAS_SPAN_SHIFT = 25;
    localparam int          BAND_SPAN_SHIFT  = 20;

    // ------------------------------------------------------------
    // alias arithmetic: 32 alias bytes per band byte, 4 per bit
    // ------------------------------------------------------------
    localparam int          BYTE_SHIFT      = 5;
    localparam int          BIT_SHIFT       = 2;
    localparam int          WORD_SHIFT      = 2;
    localparam int          WORD_BYTES      = 4;
    localparam int          LANE_BITS       = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        READY_RST       = 1'b1;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

endpackage : bit_band_pkg

/* core/band_ram.sv */
`timescale 1ns/1ps
module band_ram #(
    parameter int WORDS = 256,
    parameter int AW    = 8
) (
    input  wire logic          clock_i,
    input  wire logic          srst_i,
    input  wire logic          en_i,
    input  wire logic          we_i,
    input  wire logic [3:0]    be_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [31:0]   wdata_i,
    output logic      [31:0]   q_o
);

    logic [31:0] mem_r [WORDS];
    logic [31:0] q_r;

    // ------------------------------------------------------------
    // storage; lane 0 is the lowest byte address
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (en_i && we_i) begin
            for (int l = 0; l < 4; l++) begin
                if (be_i[l]) begin
                    mem_r[addr_i][l*8 +: 8] <= wdata_i[l*8 +: 8];
                end
            end
        end
    end

    // storage itself is not cleared; only the read register is
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            q_r <= 32'h0000_0000;
        end else if (en_i && !we_i) begin
            q_r <= mem_r[addr_i];
        end
    end

    assign q_o = q_r;

endmodule : band_ram

/* verification/core_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// processor core side: one access at a time
// ------------------------------------------------------------
module core_model (
    input  wire logic        clock_i,
    input  wire logic        req_ready_i,
    input  wire logic        rsp_valid_i,
    input  wire logic [31:0] rsp_rdata_i,
    input  wire logic        rsp_err_i,
    output logic             req_valid_o,
    output logic             req_write_o,
    output logic [31:0]      req_addr_o,
    output logic [31:0]      req_wdata_o,
    output logic [3:0]       req_be_o
);
    bit pending = 1'b0;

    initial begin
        req_valid_o = 1'b0;
        req_write_o = 1'b0;
        req_addr_o  = 32'h0000_0000;
        req_wdata_o = 32'h0000_0000;
        req_be_o    = 4'h0;
    end

    // nowait keeps the request up so the next one lands in the busy cycle
    task automatic access(input bit w, input logic [31:0] a, input logic [31:0] d,
                          input logic [3:0] be, input bit nowait,
                          output logic [31:0] rdata, output logic err, output int lat);
        int n;
        if (!pending) @(posedge clock_i);
        req_valid_o <= 1'b1;
        req_write_o <= w;
        req_addr_o  <= a;
        req_wdata_o <= d;
        req_be_o    <= be;
        n = 0;
        #1;
        while (req_ready_i !== 1'b1 && n < 50) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        @(posedge clock_i);
        pending = nowait;
        lat = 0;
        rdata = 32'h0000_0000;
        err = 1'b0;
        if (!nowait) begin
            // released address, data and byte-enable lines never keep the stale value
            req_valid_o <= 1'b0;
            req_addr_o  <= ~a;
            req_wdata_o <= ~d;
            req_be_o    <= ~be;
            #1;
            lat = 1;
            while (rsp_valid_i !== 1'b1 && lat < 50) begin
                @(posedge clock_i);
                #1;
                lat++;
            end
            rdata = rsp_rdata_i;
            err   = rsp_err_i;
        end
    endtask : access
endmodule : core_model

/* verification/bit_band_alias_mapper_tb_top.sv */
`timescale 1ns/1ps
module bit_band_alias_mapper_tb_top;
    logic        clock_i = 1'b0;
    logic        srst_i  = 1'b1;
    logic        req_valid, req_write, req_ready, rsp_valid, rsp_err;
    logic [31:0] req_addr, req_wdata, rsp_rdata;
    logic [3:0]  req_be;
    int          bad_count = 0;
    int          checks    = 0;

    initial forever #5 clock_i = ~clock_i;

    bit_band_alias_mapper #(.DEPTH_WORDS(16)) uut (
        .clock_i(clock_i), .srst_i(srst_i), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .req_be_i(req_be), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
        .rsp_rdata_o(rsp_rdata), .rsp_err_o(rsp_err));

    core_model u_core (
        .clock_i(clock_i), .req_ready_i(req_ready), .rsp_valid_i(rsp_valid),
        .rsp_rdata_i(rsp_rdata), .rsp_err_i(rsp_err), .req_valid_o(req_valid),
        .req_write_o(req_write), .req_addr_o(req_addr), .req_wdata_o(req_wdata),
        .req_be_o(req_be));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        int          lat;
        u_core.access(1'b0, a, 32'h0000_0000, 4'h0, 1'b0, q, e, lat);
        check(q, exp);
        check({31'h0, e}, 32'h0000_0000);
        check(32'(lat), 32'h0000_0002);
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                      input int exp_lat);
        logic [31:0] q;
        logic        e;
        int          lat;
        u_core.access(1'b1, a, d, be, 1'b0, q, e, lat);
        check({31'h0, e}, 32'h0000_0000);
        check(32'(lat), 32'(exp_lat));
    endtask : wr

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_alias_map;
        wr(32'h2000_0000, 32'h0000_0000, 4'hf, 1);
        wr(32'h2200_001c, 32'h0000_00ff, 4'h0, 2);
        rd(32'h2000_0000, 32'h0000_0080);
        wr(32'h2200_0000, 32'h0000_0001, 4'h0, 2);
        rd(32'h2000_0000, 32'h0000_0081);
        rd(32'h2200_001c, 32'h0000_0001);
        rd(32'h2200_0004, 32'h0000_0000);
        wr(32'h2200_001c, 32'h0000_000e, 4'h0, 2);
        rd(32'h2000_0000, 32'h0000_0001);
        wr(32'h2200_0000, 32'hffff_fffe, 4'h0, 2);
        rd(32'h2000_0000, 32'h0000_0000);
    endtask : test_alias_map

    task automatic test_byte_order;
        wr(32'h2000_0004, 32'h1122_3344, 4'hf, 1);
        rd(32'h2200_0088, 32'h0000_0001);
        rd(32'h2200_00f0, 32'h0000_0001);
        rd(32'h2200_00e4, 32'h0000_0000);
        wr(32'h2000_0004, 32'haa00_0000, 4'h8, 1);
        rd(32'h2200_00fc, 32'h0000_0001);
        rd(32'h2200_00f0, 32'h0000_0000);
    endtask : test_byte_order

    task automatic test_single_bit;
        for (int i = 0; i < 8; i++)
            wr(32'h2200_00a0 + 32'(i * 4), 32'hffff_ffff, 4'h0, 2);
        // band byte 5 sits in lane 1 of the second word
        rd(32'h2000_0004, 32'haa22_ff44);
        wr(32'h2200_00c4, 32'h0000_0002, 4'h0, 2);
        rd(32'h2000_0004, 32'haa20_ff44);
    endtask : test_single_bit

    task automatic test_atomic;
        logic [31:0] q;
        logic        e;
        int          lat;
        wr(32'h2000_0008, 32'h0000_0000, 4'hf, 1);
        u_core.access(1'b1, 32'h2200_010c, 32'h0000_0001, 4'h0, 1'b1, q, e, lat);
        u_core.access(1'b1, 32'h2000_0008, 32'h0000_0040, 4'h1, 1'b0, q, e, lat);
        check(32'(lat), 32'h0000_0001);
        rd(32'h2000_0008, 32'h0000_0040);
    endtask : test_atomic

    task automatic test_errors;
        logic [31:0] bad_addr [3] = '{32'h3000_0000, 32'h2000_0040, 32'h2200_0800};
        logic [31:0] q;
        logic        e;
        int          lat;
        foreach (bad_addr[i]) begin
            u_core.access(1'b0, bad_addr[i], 32'h0000_0000, 4'h0, 1'b0, q, e, lat);
            check({31'h0, e}, 32'h0000_0001);
            check(32'(lat), 32'h0000_0001);
            check(q, 32'h0000_0000);
        end
    endtask : test_errors

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        #1;
        check({28'h0, req_ready, rsp_valid, rsp_err, 1'b0}, 32'h0000_0008);
        check(rsp_rdata, 32'h0000_0000);
        test_alias_map();
        test_byte_order();
        test_single_bit();
        test_atomic();
        test_errors();
        complete_run();
    end

    // whole run is about a hundred cycles
    initial begin
        #50000;
        bad_count++;
        complete_run();
    end
endmodule : bit_band_alias_mapper_tb_top
